// ===== shared/soft_ramp_pkg.sv
// Purpose: Constants, types and decoders for the soft-start/soft-stop block.
// Assumes: 250 MHz system clock; every ramp and delay is a multiple of 0.5 ms.
// Notes:   Times are kept in microseconds and turned into quanta of 0.5 ms.
// Function
// R1: Soft-start code 000..011 gives 1, 2, 4, 8 ms; 100..111 give 16 ms.
// R2: Soft-start runs from first rise until the output reaches regulation.
// R3: Selected soft-start time sets the reference DAC slew rate at startup.
// R4: Time matches only for the VID target; host offset or boot command alter it.
// R5: Stop-delay code 00..11 waits 0, 1, 1.5, 2 ms before soft-stop.
// R6: Stop delay counts from the stop condition as the on/off setting defines.
// R7: Soft-stop disabled forces zero delay and tri-states switches at once.
// R8: Soft-stop code 00..11 ramps reference to 0 mV in 0.5, 1, 2, 4 ms.
// R9: During soft-stop, switching halts once the output falls to 200 mV.
// R10: Unused upper bits of the three timing registers always read zero.
// R11: Reference DAC steps linearly, rate from ramp time and target voltage.
package soft_ramp_pkg;

  localparam int CLK_MHZ         = 250;
  localparam int QUANTUM_US      = 500;
  localparam int QUANTUM_CYCLES  = QUANTUM_US * CLK_MHZ;

  localparam int SS_TIME_US   [5] = '{1000, 2000, 4000, 8000, 16000};
  localparam int DLY_TIME_US  [4] = '{0, 1000, 1500, 2000};
  localparam int FALL_TIME_US [4] = '{500, 1000, 2000, 4000};

  localparam logic [7:0] ADDR_SOFT_START = 8'h61;
  localparam logic [7:0] ADDR_STOP_DELAY = 8'h64;
  localparam logic [7:0] ADDR_SOFT_STOP  = 8'h65;

  localparam int SS_SEL_LSB   = 0;
  localparam int SS_SEL_W     = 3;
  localparam int DLY_SEL_LSB  = 0;
  localparam int DLY_SEL_W    = 2;
  localparam int FALL_SEL_LSB = 0;
  localparam int FALL_SEL_W   = 2;

  localparam logic [2:0] SS_SEL_RST   = 3'h0;
  localparam logic [1:0] DLY_SEL_RST  = 2'h0;
  localparam logic [1:0] FALL_SEL_RST = 2'h0;
  localparam logic [7:0] READ_UNMAPPED = 8'h00;

  localparam int DAC_W = 8;

  typedef struct packed {
    logic       valid;
    logic       write;
    logic [7:0] code;
    logic [7:0] wdata;
  } cmd_req_type;

  typedef struct packed {
    logic [SS_SEL_W-1:0]   ss;
    logic [DLY_SEL_W-1:0]  dly;
    logic [FALL_SEL_W-1:0] fall;
  } cfg_type;

  typedef enum logic [4:0] {
    ST_OFF   = 5'h01,
    ST_RISE  = 5'h02,
    ST_REG   = 5'h04,
    ST_DELAY = 5'h08,
    ST_FALL  = 5'h10
  } ramp_state_type;

  function automatic int unsigned ss_quanta(input logic [2:0] sel);
    int idx;
    idx = (sel > 3'h3) ? 4 : int'(sel);
    return SS_TIME_US[idx] / QUANTUM_US;
  endfunction

  function automatic int unsigned dly_quanta(input logic [1:0] sel);
    return (2 * DLY_TIME_US[sel]) / (2 * QUANTUM_US);
  endfunction

  function automatic int unsigned fall_quanta(input logic [1:0] sel);
    return FALL_TIME_US[sel] / QUANTUM_US;
  endfunction

endpackage

// ===== hdl/ref_ramp.sv
// Purpose: Linear reference DAC ramp from a start code to a final code.
// Assumes: span never exceeds dur, so the code moves at most one per cycle.
// Notes:   Bresenham stepping spreads span code steps evenly over dur cycles.
`timescale 1ns/100ps
module ref_ramp #(
  parameter int W = 8
) (
  input  wire logic          sys_clk,
  input  wire logic          rst_n,
  input  wire logic          load,
  input  wire logic          down,
  input  wire logic [W-1:0]  start_code,
  input  wire logic [W-1:0]  final_code,
  input  wire logic [W-1:0]  span,
  input  wire logic [31:0]   dur,
  output logic      [W-1:0]  code,
  output logic               done
);

  typedef struct packed {
    logic [W-1:0] code;
    logic [W-1:0] final_code;
    logic [W-1:0] span;
    logic [31:0]  dur;
    logic [31:0]  acc;
    logic         down;
    logic         active;
  } ramp_reg_type;

  ramp_reg_type s_reg;
  ramp_reg_type s_next;
  logic [31:0]  acc_sum;

  always_comb begin
    s_next  = s_reg;
    acc_sum = s_reg.acc + 32'(s_reg.span);
    if (load) begin
      s_next.code       = start_code;
      s_next.final_code = final_code;
      s_next.span       = span;
      s_next.dur        = dur;
      s_next.acc        = 32'h0;
      s_next.down       = down;
      s_next.active     = (start_code != final_code);
    end else if (s_reg.active) begin
      // Accumulate the span each cycle; a step falls due each time the sum reaches dur. [R11]
      if (acc_sum >= s_reg.dur) begin
        s_next.acc  = acc_sum - s_reg.dur;
        s_next.code = s_reg.down ? s_reg.code - 1'b1 : s_reg.code + 1'b1;
        if (s_next.code == s_reg.final_code) begin
          s_next.active = 1'b0;
        end
      end else begin
        s_next.acc = acc_sum;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign code = s_reg.code;
  // Done is taken from the register alone. The sequencer decides its load
  // from done, so a path from load back to done would loop in one cycle.
  assign done = !s_reg.active;

endmodule // ref_ramp

// ===== hdl/soft_start_stop_timing.sv
// Purpose: Timing registers and ramp sequencer for converter start and stop.
// Assumes: Command port is the byte interface behind the serial host engine.
// Notes:   Timing register defaults come from nonvolatile inputs after reset.
`timescale 1ns/100ps
module soft_start_stop_timing #(
  parameter int unsigned CYCLES_PER_QUANTUM = soft_ramp_pkg::QUANTUM_CYCLES
) (
  input  wire logic                             sys_clk,
  input  wire logic                             rst_n,
  input  wire soft_ramp_pkg::cmd_req_type       cmd,
  output logic                                  rd_valid,
  output logic      [7:0]                       rd_data,
  input  wire soft_ramp_pkg::cfg_type           nvm_cfg,
  input  wire logic                             start_cond,
  input  wire logic                             stop_cond,
  input  wire logic                             soft_stop_enable,
  input  wire logic [soft_ramp_pkg::DAC_W-1:0]  vid_target,
  input  wire logic [soft_ramp_pkg::DAC_W-1:0]  host_offset,
  input  wire logic                             host_boot_sel,
  input  wire logic [soft_ramp_pkg::DAC_W-1:0]  host_vout_cmd,
  input  wire logic                             vout_below_200mv,
  output logic      [soft_ramp_pkg::DAC_W-1:0]  ref_dac,
  output logic                                  switch_enable,
  output logic                                  in_regulation
);

  localparam int DW = soft_ramp_pkg::DAC_W;

  typedef struct packed {
    soft_ramp_pkg::ramp_state_type st;
    soft_ramp_pkg::cfg_type        cfg;
    logic                          loaded;
    logic [31:0]                   timer;
    logic                          rd_valid;
    logic [7:0]                    rd_data;
    logic                          sw_on;
  } ctl_reg_type;

  ctl_reg_type       s_reg;
  ctl_reg_type       s_next;
  logic              ramp_load;
  logic              ramp_down;
  logic [DW-1:0]     ramp_start;
  logic [DW-1:0]     ramp_final;
  logic [DW-1:0]     ramp_span;
  logic [31:0]       ramp_dur;
  logic              ramp_done;
  logic [DW-1:0]     ramp_code;
  logic [DW-1:0]     final_target;
  logic [31:0]       ss_cycles;
  logic [31:0]       dly_cycles;
  logic [31:0]       fall_cycles;
  logic              stop_ok;

  // The on/off setting that qualifies stop_cond lives outside this block. [R6]
  assign stop_ok = stop_cond;

  // Slew comes from the VID target, so a host offset or boot command
  // lengthens or shortens the ramp rather than changing its slope. [R4]
  assign final_target = host_boot_sel ? host_vout_cmd
                                      : vid_target + host_offset;

  assign ss_cycles   = 32'(soft_ramp_pkg::ss_quanta(s_reg.cfg.ss)
                           * CYCLES_PER_QUANTUM); // [R1]
  assign dly_cycles  = soft_stop_enable
                     ? 32'(soft_ramp_pkg::dly_quanta(s_reg.cfg.dly)
                           * CYCLES_PER_QUANTUM)
                     : 32'h0; // [R5] [R7]
  assign fall_cycles = 32'(soft_ramp_pkg::fall_quanta(s_reg.cfg.fall)
                           * CYCLES_PER_QUANTUM); // [R8]

  function automatic logic [7:0] read_mux(
    input logic [7:0]             code,
    input soft_ramp_pkg::cfg_type cfg
  );
    logic [7:0] r;
    r = soft_ramp_pkg::READ_UNMAPPED;
    unique case (code)
      soft_ramp_pkg::ADDR_SOFT_START: r = {5'h00, cfg.ss};   // [R10]
      soft_ramp_pkg::ADDR_STOP_DELAY: r = {6'h00, cfg.dly};  // [R10]
      soft_ramp_pkg::ADDR_SOFT_STOP:  r = {6'h00, cfg.fall}; // [R10]
      default:                        r = soft_ramp_pkg::READ_UNMAPPED;
    endcase
    return r;
  endfunction

  always_comb begin
    s_next     = s_reg;
    ramp_load  = 1'b0;
    ramp_down  = 1'b0;
    ramp_start = '0;
    ramp_final = '0;
    ramp_span  = '0;
    ramp_dur   = 32'h1;

    s_next.rd_valid = cmd.valid && !cmd.write;
    s_next.rd_data  = read_mux(cmd.code, s_reg.cfg);

    // Defaults are caught one edge after reset release; a write in that
    // very cycle is overwritten by the stored value.
    if (!s_reg.loaded) begin
      s_next.cfg    = nvm_cfg;
      s_next.loaded = 1'b1;
    end else if (cmd.valid && cmd.write) begin
      unique case (cmd.code)
        soft_ramp_pkg::ADDR_SOFT_START:
          s_next.cfg.ss = cmd.wdata[soft_ramp_pkg::SS_SEL_LSB +:
                                    soft_ramp_pkg::SS_SEL_W];
        soft_ramp_pkg::ADDR_STOP_DELAY:
          s_next.cfg.dly = cmd.wdata[soft_ramp_pkg::DLY_SEL_LSB +:
                                     soft_ramp_pkg::DLY_SEL_W];
        soft_ramp_pkg::ADDR_SOFT_STOP:
          s_next.cfg.fall = cmd.wdata[soft_ramp_pkg::FALL_SEL_LSB +:
                                      soft_ramp_pkg::FALL_SEL_W];
        default: ;
      endcase
    end

    unique case (s_reg.st)
      soft_ramp_pkg::ST_OFF: begin
        if (start_cond && s_reg.loaded) begin
          s_next.st    = soft_ramp_pkg::ST_RISE;
          s_next.sw_on = 1'b1;
          ramp_load    = 1'b1;
          ramp_final   = final_target;
          ramp_span    = vid_target; // [R3]
          ramp_dur     = ss_cycles;  // [R3]
        end
      end
      soft_ramp_pkg::ST_RISE, soft_ramp_pkg::ST_REG: begin
        if (stop_ok) begin
          ramp_load  = 1'b1;
          ramp_start = ramp_code;
          if (!soft_stop_enable) begin
            // No soft-stop: reference drops and switches go high-Z now. [R7]
            s_next.st    = soft_ramp_pkg::ST_OFF;
            s_next.sw_on = 1'b0;
            ramp_start   = '0;
          end else if (dly_cycles == 32'h0) begin
            s_next.st = soft_ramp_pkg::ST_FALL; // [R5]
            ramp_down = 1'b1;
            ramp_span = ramp_code;
            ramp_dur  = fall_cycles; // [R8]
          end else begin
            // Hold the reference where it is while the delay runs. [R6]
            s_next.st    = soft_ramp_pkg::ST_DELAY;
            s_next.timer = dly_cycles - 32'h1;
            ramp_final   = ramp_code;
          end
        end else if (s_reg.st == soft_ramp_pkg::ST_RISE && ramp_done) begin
          s_next.st = soft_ramp_pkg::ST_REG; // [R2]
        end
      end
      soft_ramp_pkg::ST_DELAY: begin
        if (s_reg.timer == 32'h0) begin
          s_next.st  = soft_ramp_pkg::ST_FALL;
          ramp_load  = 1'b1;
          ramp_down  = 1'b1;
          ramp_start = ramp_code;
          ramp_span  = ramp_code;
          ramp_dur   = fall_cycles; // [R8]
        end else begin
          s_next.timer = s_reg.timer - 32'h1; // [R5]
        end
      end
      soft_ramp_pkg::ST_FALL: begin
        // Stop at 200 mV rather than waiting for the ramp to finish. [R9]
        if (vout_below_200mv || ramp_done) begin
          s_next.st    = soft_ramp_pkg::ST_OFF;
          s_next.sw_on = 1'b0;
          ramp_load    = 1'b1;
        end
      end
      default: begin
        s_next.st    = soft_ramp_pkg::ST_OFF;
        s_next.sw_on = 1'b0;
      end
    endcase
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      s_reg          <= '0;
      s_reg.st       <= soft_ramp_pkg::ST_OFF;
      s_reg.cfg.ss   <= soft_ramp_pkg::SS_SEL_RST;
      s_reg.cfg.dly  <= soft_ramp_pkg::DLY_SEL_RST;
      s_reg.cfg.fall <= soft_ramp_pkg::FALL_SEL_RST;
    end else begin
      s_reg <= s_next;
    end
  end

  ref_ramp #(
    .W (DW)
  ) u_ramp (
    .sys_clk    (sys_clk),
    .rst_n      (rst_n),
    .load       (ramp_load),
    .down       (ramp_down),
    .start_code (ramp_start),
    .final_code (ramp_final),
    .span       (ramp_span),
    .dur        (ramp_dur),
    .code       (ramp_code),
    .done       (ramp_done)
  );

  assign ref_dac       = ramp_code;
  assign switch_enable = s_reg.sw_on;
  assign in_regulation = (s_reg.st == soft_ramp_pkg::ST_REG);
  assign rd_valid      = s_reg.rd_valid;
  assign rd_data       = s_reg.rd_data;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  a_ss_long_codes: assert property ( // [R1]
    s_reg.cfg.ss[2] |-> ss_cycles == 32'(32 * CYCLES_PER_QUANTUM))
    else $error("Soft-start codes 4 to 7 must select 16 ms.");
  a_rise_to_reg: assert property ( // [R2]
    (s_reg.st == soft_ramp_pkg::ST_RISE && ramp_done && !stop_ok)
    |=> in_regulation && switch_enable)
    else $error("Finished soft-start did not enter regulation.");
  a_rise_start: assert property ( // [R3]
    (s_reg.st == soft_ramp_pkg::ST_OFF && start_cond && s_reg.loaded)
    |=> switch_enable && ref_dac == 8'h00)
    else $error("Start condition did not begin the ramp from zero.");
  a_off_immediate: assert property ( // [R7]
    (!soft_stop_enable && stop_ok && (s_reg.st == soft_ramp_pkg::ST_REG))
    |=> !switch_enable && ref_dac == 8'h00)
    else $error("Disabled soft-stop did not switch off at once.");
  a_delay_hold: assert property ( // [R5]
    (s_reg.st == soft_ramp_pkg::ST_DELAY && s_reg.timer != 32'h0)
    |=> s_reg.st == soft_ramp_pkg::ST_DELAY && $stable(ref_dac))
    else $error("Stop delay ended early or moved the reference.");
  a_delay_count: assert property ( // [R6]
    (s_reg.st != soft_ramp_pkg::ST_DELAY ##1
     s_reg.st == soft_ramp_pkg::ST_DELAY) |-> s_reg.timer == dly_cycles - 1)
    else $error("Stop delay counter loaded with wrong length.");
  a_fall_zero_delay: assert property ( // [R8]
    (soft_stop_enable && stop_ok && s_reg.cfg.dly == 2'h0 &&
     s_reg.st == soft_ramp_pkg::ST_REG) |=> s_reg.st == soft_ramp_pkg::ST_FALL)
    else $error("Zero stop delay did not start soft-stop next cycle.");
  a_fall_cut: assert property ( // [R9]
    (s_reg.st == soft_ramp_pkg::ST_FALL && vout_below_200mv)
    |=> !switch_enable ##1 !switch_enable)
    else $error("Switching continued below 200 mV.");
  a_reserved_zero: assert property ( // [R10]
    (cmd.valid && !cmd.write && cmd.code == soft_ramp_pkg::ADDR_SOFT_START)
    |=> rd_valid && rd_data[7:3] == 5'h00)
    else $error("Reserved soft-start bits read nonzero.");
  a_ramp_linear: assert property ( // [R11]
    (s_reg.st == soft_ramp_pkg::ST_RISE && $past(s_reg.st) ==
     soft_ramp_pkg::ST_RISE) |-> (ref_dac - $past(ref_dac)) <= 8'h01)
    else $error("Soft-start reference moved by more than one step.");

  c_full_cycle: cover property (s_reg.st == soft_ramp_pkg::ST_DELAY
                                ##1 s_reg.st == soft_ramp_pkg::ST_FALL);
  c_reg_reached: cover property ($rose(in_regulation));
  c_cut_200mv: cover property (s_reg.st == soft_ramp_pkg::ST_FALL &&
                               vout_below_200mv);
  c_hard_off: cover property (!soft_stop_enable && stop_ok && switch_enable);

endmodule // soft_start_stop_timing

// ===== verification/host_model.sv
// Purpose: Host-side command master for the converter timing registers.
// Assumes: One byte per access; a read answer stands the cycle after.
// Notes:   Idle command lines carry inverted values, never the last byte.
`timescale 1ns/100ps
module host_model (
  input  wire logic                  sys_clk,
  output soft_ramp_pkg::cmd_req_type cmd,
  input  wire logic                  rd_valid,
  input  wire logic [7:0]            rd_data
);
  initial cmd = '0;

  task automatic wr(input logic [7:0] c, input logic [7:0] d);
    @(posedge sys_clk);
    #1;
    cmd = '{valid: 1'b1, write: 1'b1, code: c, wdata: d};
    @(posedge sys_clk);
    #1;
    cmd = '{valid: 1'b0, write: 1'b0, code: ~c, wdata: ~d};
  endtask

  // The answer is taken just after the taking edge, while it stands.
  task automatic rd(input logic [7:0] c, output logic [7:0] q);
    @(posedge sys_clk);
    #1;
    cmd = '{valid: 1'b1, write: 1'b0, code: c, wdata: 8'h5a};
    @(posedge sys_clk);
    #1;
    cmd = '{valid: 1'b0, write: 1'b0, code: ~c, wdata: 8'ha5};
    q = (rd_valid === 1'b1) ? rd_data : 8'hxx;
  endtask
endmodule // host_model

// ===== verification/tb_top.sv
// Purpose: Self-checking bench for soft start/stop timing and registers.
// Assumes: Quantum shortened to 20 cycles so whole ramps stay short.
// Notes:   Time windows allow a few cycles of pipeline slack.
`timescale 1ns/100ps
module tb_top;
  localparam int Q = 20;
  logic                       sys_clk;
  logic                       rst_n;
  soft_ramp_pkg::cmd_req_type cmd;
  logic                       rd_valid;
  logic [7:0]                 rd_data;
  soft_ramp_pkg::cfg_type     nvm_cfg;
  logic                       start_cond;
  logic                       stop_cond;
  logic                       soft_stop_enable;
  logic [7:0]                 vid_target;
  logic [7:0]                 host_offset;
  logic                       host_boot_sel;
  logic [7:0]                 host_vout_cmd;
  logic                       vout_below_200mv;
  logic [7:0]                 ref_dac;
  logic                       switch_enable;
  logic                       in_regulation;
  logic [7:0]                 prev_ref;
  logic [7:0]                 q;
  logic [31:0]                seed;
  int                         error_cnt;
  int                         compares;
  logic [7:0] codes [6] = '{8'h61, 8'h64, 8'h65, 8'h60, 8'h66, 8'h00};

  soft_start_stop_timing #(.CYCLES_PER_QUANTUM(Q)) dut_u (
    .sys_clk(sys_clk), .rst_n(rst_n), .cmd(cmd), .rd_valid(rd_valid),
    .rd_data(rd_data), .nvm_cfg(nvm_cfg), .start_cond(start_cond),
    .stop_cond(stop_cond), .soft_stop_enable(soft_stop_enable),
    .vid_target(vid_target), .host_offset(host_offset),
    .host_boot_sel(host_boot_sel), .host_vout_cmd(host_vout_cmd),
    .vout_below_200mv(vout_below_200mv), .ref_dac(ref_dac),
    .switch_enable(switch_enable), .in_regulation(in_regulation));
  host_model host_u (.sys_clk(sys_clk), .cmd(cmd), .rd_valid(rd_valid),
    .rd_data(rd_data));

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic int ss_q(input int s);
    return (s > 3) ? 32 : (2 << s);
  endfunction
  function automatic logic [7:0] rd_exp(input logic [7:0] c,
                                        input logic [7:0] w);
    case (c)
      8'h61:        return w & 8'h07;
      8'h64, 8'h65: return w & 8'h03;
      default:      return 8'h00;
    endcase
  endfunction

  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    compares++;
    if (g !== e) begin
      error_cnt++;
      $display("BAD %s expected %0h seen %0h", nm, e, g);
    end
  endtask
  task automatic win(input string nm, input int lo, input int hi,
                     input int n);
    compares++;
    if (n < lo || n > hi) begin
      error_cnt++;
      $display("BAD %s expected %0d..%0d seen %0d", nm, lo, hi, n);
    end
  endtask
  task automatic tick();
    @(posedge sys_clk);
    #1;
  endtask
  task automatic results();
    if (error_cnt == 0 && compares > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // Kind 1 adds an offset equal to the target, kind 2 boots from the host
  // code; both double the final code, so the ramp takes twice as long.
  task automatic rise(input logic [2:0] s, input int k);
    int          n;
    logic [31:0] w;
    n = 0;
    w = rnd();
    host_u.wr(8'h61, {w[7:3], s});
    host_offset = (k == 1) ? vid_target : 8'h00;
    host_boot_sel = (k == 2);
    start_cond = 1'b1;
    tick();
    start_cond = 1'b0;
    while (in_regulation !== 1'b1 && n < 3000) begin
      tick();
      n++;
    end
    w = ss_q(s) * Q * ((k == 0) ? 1 : 2);
    win("rise_time", w, w + 5, n);
    chk("rise_final", (k == 0) ? vid_target : host_vout_cmd, ref_dac);
    chk("rise_switch", 1, switch_enable);
  endtask

  task automatic stop_seq(input logic en, input int d, input int f,
                          input logic early);
    int          n;
    int          m;
    int          dq;
    logic [7:0]  r0;
    logic [31:0] w;
    n = 0;
    m = 0;
    dq = (d == 0) ? 0 : d + 1;
    w = rnd();
    host_u.wr(8'h64, {w[7:2], d[1:0]});
    host_u.wr(8'h65, {w[15:10], f[1:0]});
    r0 = ref_dac;
    soft_stop_enable = en;
    stop_cond = 1'b1;
    tick();
    stop_cond = 1'b0;
    while (en && ref_dac === r0 && n < 3000) begin
      tick();
      n++;
    end
    w = dq * Q + (Q << f) / 4 + 3;
    if (en) win("stop_delay", dq * Q, w, n);
    if (early) vout_below_200mv = 1'b1;
    while (switch_enable === 1'b1 && m < 3000) begin
      tick();
      m++;
    end
    vout_below_200mv = 1'b0;
    if (!en) win("stop_now", 0, 2, m);
    else if (early) win("stop_early", 0, 2, m);
    else win("stop_total", (dq + (1 << f)) * Q, (dq + (1 << f)) * Q + 5,
             n + m);
    chk("stop_ref", 0, ref_dac);
    chk("stop_reg", 0, in_regulation);
  endtask

  // Code steps of more than one mean the ramp is not linear.
  always @(posedge sys_clk) begin
    #1;
    if (rst_n === 1'b1 && ref_dac > prev_ref)
      chk("ref_up", prev_ref + 8'h01, ref_dac);
    else if (rst_n === 1'b1 && ref_dac < prev_ref && ref_dac !== 8'h00)
      chk("ref_down", prev_ref - 8'h01, ref_dac);
    prev_ref = ref_dac;
  end

  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end

  // The whole run needs some 5,600 cycles; 50,000 leave ample margin.
  initial begin
    #200000;
    error_cnt++;
    results();
  end

  initial begin
    int          i;
    logic [31:0] w;
    seed = 32'h0000eea9;
    rst_n = 1'b0;
    start_cond = 1'b0;
    stop_cond = 1'b0;
    soft_stop_enable = 1'b0;
    host_offset = 8'h00;
    host_boot_sel = 1'b0;
    vout_below_200mv = 1'b0;
    error_cnt = 0;
    compares = 0;
    prev_ref = 8'h00;
    w = rnd();
    nvm_cfg = w[6:0];
    vid_target = 8'h08 + 8'(w[15:8] % 13);
    host_vout_cmd = vid_target << 1;
    repeat (16) @(posedge sys_clk);
    #1;
    rst_n = 1'b1;
    repeat (2) @(posedge sys_clk);
    host_u.rd(8'h61, q);
    chk("nvm_ss", {5'h00, nvm_cfg.ss}, q);
    host_u.rd(8'h64, q);
    chk("nvm_dly", {6'h00, nvm_cfg.dly}, q);
    host_u.rd(8'h65, q);
    chk("nvm_fall", {6'h00, nvm_cfg.fall}, q);
    for (i = 0; i < 6; i++) begin
      w = rnd();
      host_u.wr(codes[i], w[7:0]);
      host_u.rd(codes[i], q);
      chk("reg_rw", rd_exp(codes[i], w[7:0]), q);
    end
    for (i = 0; i < 8; i++) begin
      rise(i[2:0], 0);
      stop_seq(i != 6, i % 4, i % 4, i == 5);
    end
    rise(3'h3, 1);
    stop_seq(1'b1, 1, 2, 1'b0);
    rise(3'h3, 2);
    stop_seq(1'b1, 3, 2, 1'b1);
    results();
  end
endmodule // tb_top
